/* File: hw/otpp_top.sv */
// Programmer for the OTP memory's external programming interface.
// Assumes pin levels are realised by external drivers; data pins are open toward the memory when oe_n is high.
`default_nettype none
module otpp_top
  import otpp_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES     = PULSE_CYC,
  parameter int unsigned OPT_PULSE_CYCLES = OPT_PULSE_CYC,
  parameter int unsigned MAX_TRIES        = MAX_PULSES
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [2:0]        cmd_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic                   cmd_ready_out,
  output logic                   done_out,
  output logic                   fail_out,
  output logic [DATA_W-1:0]      rdata_out,
  output logic [4:0]             tries_out,
  output logic [1:0]             vpp_level_out,
  output logic [1:0]             mode_select_hv_out,
  output logic [1:0]             chip_sel_out,
  output logic [1:0]             out_en_out,
  output logic                   program_strobe_n_out,
  output logic                   vcc_raise_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n_out,
  input  wire logic [DATA_W-1:0] data_in
);
  // Refuse settings that the 5-bit try counter or the 32-bit phase counters cannot hold.
  if (PULSE_CYCLES < 1 || OPT_PULSE_CYCLES < 1 || MAX_TRIES < 1 || MAX_TRIES > 31 ||
      (64'(OVERPROG_FACTOR) * 64'(PULSE_CYCLES) * 64'(MAX_TRIES)) > 64'hffff_ffff) begin : g_bad_params
    $error("otpp_top: bad timing parameters");
  end

  otpp_state_t state_q;
  logic [2:0]        cmd_q;
  logic [31:0]       cnt_q;
  logic [31:0]       wait_q;
  logic [4:0]        tries_q;
  logic [DATA_W-1:0] wdata_q;

  assign cmd_ready_out = (state_q == ST_IDLE);

  // Sequencer: setup, access or pulse, verify loop, overprogram.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 32'h0;
      wait_q    <= 32'h0;
      tries_q   <= 5'h0;
      cmd_q     <= CMD_READ;
      wdata_q   <= '0;
      addr_out  <= '0;
      rdata_out <= '0;
      done_out  <= 1'b0;
      fail_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid_in) begin
            cmd_q    <= cmd_in;
            wdata_q  <= wdata_in;
            tries_q  <= 5'h0;
            fail_out <= 1'b0;
            // Protect cycles leave address lines at a valid low level.
            addr_out <= (cmd_in == CMD_MEM_PROTECT || cmd_in == CMD_RAM_PROTECT) ? '0 : addr_in;
            cnt_q    <= 32'h0;
            wait_q   <= SETUP_CYC;
            state_q  <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_q + 32'h1 >= wait_q) begin
            cnt_q <= 32'h0;
            if (cmd_q == CMD_READ || cmd_q == CMD_VERIFY) begin
              wait_q  <= ACCESS_CYC;
              state_q <= ST_ACCESS;
            end else begin
              wait_q  <= (cmd_q == CMD_PROGRAM) ? PULSE_CYCLES : OPT_PULSE_CYCLES;
              state_q <= ST_PULSE;
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_ACCESS: begin
          if (cnt_q + 32'h1 >= wait_q) begin
            rdata_out <= data_in;
            state_q   <= ST_DONE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_PULSE: begin
          if (cnt_q + 32'h1 >= wait_q) begin
            cnt_q <= 32'h0;
            if (cmd_q == CMD_PROGRAM) begin
              tries_q <= tries_q + 5'h1;
              wait_q  <= SETUP_CYC;
              state_q <= ST_VSETUP;
            end else begin
              state_q <= ST_DONE;
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_VSETUP: begin
          if (cnt_q + 32'h1 >= wait_q) begin
            cnt_q   <= 32'h0;
            wait_q  <= ACCESS_CYC;
            state_q <= ST_VACCESS;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_VACCESS: begin
          if (cnt_q + 32'h1 >= wait_q) begin
            cnt_q     <= 32'h0;
            rdata_out <= data_in;
            // Verify after each ST_PULSE program pulse decides between overprogram, retry and giving up with fail_out.
            if (data_in == wdata_q) begin
              wait_q  <= OVERPROG_FACTOR * PULSE_CYCLES * 32'(tries_q);
              state_q <= ST_OVER;
            end else if (32'(tries_q) >= MAX_TRIES) begin
              fail_out <= 1'b1;
              state_q  <= ST_DONE;
            end else begin
              wait_q  <= PULSE_CYCLES;
              state_q <= ST_PULSE;
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_OVER: begin
          if (cnt_q + 32'h1 >= wait_q) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_DONE: begin
          done_out <= 1'b1;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign tries_out = tries_q;

  // Pin levels per mode; every control is driven to a defined level at all times.
  logic pgm_phase;
  logic rd_phase;
  assign pgm_phase = (state_q == ST_PULSE) || (state_q == ST_OVER);
  assign rd_phase  = (state_q == ST_ACCESS) || (state_q == ST_VSETUP) || (state_q == ST_VACCESS) ||
                     ((state_q == ST_SETUP) && (cmd_q == CMD_READ || cmd_q == CMD_VERIFY));

  always_comb begin
    vpp_level_out        = LVL_LOW;
    mode_select_hv_out   = LVL_HIGH;
    chip_sel_out         = LVL_HIGH;
    out_en_out           = LVL_HIGH;
    program_strobe_n_out = 1'b1;
    vcc_raise_out        = 1'b0;
    data_out             = '0;
    data_oe_n_out        = 1'b1;
    if (state_q != ST_IDLE && state_q != ST_DONE) begin
      case (cmd_q)
        CMD_READ: begin
          mode_select_hv_out = LVL_HV;
          chip_sel_out       = LVL_LOW;
          out_en_out         = rd_phase ? LVL_LOW : LVL_HIGH;
        end
        CMD_VERIFY, CMD_PROGRAM: begin
          vpp_level_out        = LVL_HV;
          vcc_raise_out        = 1'b1;
          chip_sel_out         = LVL_LOW;
          out_en_out           = rd_phase ? LVL_LOW : LVL_HIGH;
          program_strobe_n_out = ~pgm_phase;
          data_out             = wdata_q;
          data_oe_n_out        = rd_phase;
        end
        CMD_MEM_PROTECT: begin
          vpp_level_out        = LVL_HV;
          vcc_raise_out        = 1'b1;
          mode_select_hv_out   = LVL_HV;
          chip_sel_out         = LVL_HV;
          program_strobe_n_out = ~pgm_phase;
          data_oe_n_out        = 1'b0;
        end
        CMD_RAM_PROTECT: begin
          vpp_level_out        = LVL_HV;
          vcc_raise_out        = 1'b1;
          chip_sel_out         = LVL_HV;
          out_en_out           = LVL_HV;
          program_strobe_n_out = ~pgm_phase;
          data_oe_n_out        = 1'b0;
        end
        default: ;
      endcase
    end
  end

  logic [31:0] low_cnt_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_cnt_q <= 32'h0;
    end else begin
      low_cnt_q <= program_strobe_n_out ? 32'h0 : low_cnt_q + 32'h1;
    end
  end

  read_strobe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (out_en_out == LVL_LOW) |-> program_strobe_n_out) else $error("strobe during output enable");
  verify_supply_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_q == ST_VACCESS) |-> (vcc_raise_out && vpp_level_out == LVL_HV)) else $error("verify supply");
  // At the edge that sees the strobe high again, the counter still holds the whole low phase.
  option_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($rose(program_strobe_n_out) && cmd_q != CMD_PROGRAM) |-> (low_cnt_q >= OPT_PULSE_CYCLES))
    else $error("option pulse too short");
  prog_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($rose(program_strobe_n_out) && cmd_q == CMD_PROGRAM) |-> (low_cnt_q >= PULSE_CYCLES))
    else $error("program pulse too short");
  try_limit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    32'(tries_q) <= MAX_TRIES) else $error("too many pulses");
  verify_then_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_q == ST_PULSE && cmd_q == CMD_PROGRAM && cnt_q + 32'h1 >= wait_q) |=> (state_q == ST_VSETUP))
    else $error("no verify after pulse");
  protect_lines_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_q != ST_IDLE && state_q != ST_DONE && (cmd_q == CMD_MEM_PROTECT || cmd_q == CMD_RAM_PROTECT)) |->
    (!data_oe_n_out && addr_out == '0)) else $error("protect lines floating");
  over_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_q == ST_OVER) |-> (wait_q == OVERPROG_FACTOR * PULSE_CYCLES * 32'(tries_q)))
    else $error("overprogram length");
  defined_ctl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (chip_sel_out != 2'h3 && out_en_out != 2'h3 && vpp_level_out != 2'h3)) else $error("undefined level");

  read_c: cover property (@(posedge clk_in) state_q == ST_ACCESS && cmd_q == CMD_READ);
  prog_ok_c: cover property (@(posedge clk_in) state_q == ST_OVER);
  prog_fail_c: cover property (@(posedge clk_in) fail_out);
  protect_c: cover property (@(posedge clk_in) state_q == ST_PULSE && cmd_q == CMD_MEM_PROTECT);
endmodule
`default_nettype wire

/* File: hw/otpp_pkg.sv */
// Constants and types for the OTP programmer that drives the memory's programming pins.
// Assumes a 250 MHz controller clock; pin levels above logic are requested through supply-select outputs.
`default_nettype none
package otpp_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SETUP_US        = 2;
  localparam int unsigned SETUP_CYC       = SETUP_US * CLK_MHZ;
  localparam int unsigned ACCESS_NS       = 200;
  localparam int unsigned ACCESS_CYC      = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_MS        = 1;
  localparam int unsigned PULSE_CYC       = PULSE_MS * CLK_MHZ * 1000;
  localparam int unsigned OPT_PULSE_MS    = 78;
  localparam int unsigned OPT_PULSE_CYC   = OPT_PULSE_MS * CLK_MHZ * 1000;
  localparam int unsigned MAX_PULSES      = 25;
  localparam int unsigned OVERPROG_FACTOR = 3;
  localparam int unsigned ADDR_W          = 13;
  localparam int unsigned DATA_W          = 8;
  localparam logic [2:0] CMD_READ         = 3'h0;
  localparam logic [2:0] CMD_VERIFY       = 3'h1;
  localparam logic [2:0] CMD_PROGRAM      = 3'h2;
  localparam logic [2:0] CMD_MEM_PROTECT  = 3'h3;
  localparam logic [2:0] CMD_RAM_PROTECT  = 3'h4;
  localparam logic [1:0] LVL_LOW          = 2'h0;
  localparam logic [1:0] LVL_HIGH         = 2'h1;
  localparam logic [1:0] LVL_HV           = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_ACCESS, ST_PULSE, ST_VSETUP, ST_VACCESS, ST_OVER, ST_HOLD, ST_DONE
  } otpp_state_t;
endpackage
`default_nettype wire

/* File: verification/otpp_dev_model.sv */
// Behavioural model of the OTP memory as it is seen through its programming pins.
// Assumes pin levels coded 0 low, 1 high, 2 high voltage, and pull-ups on the data bus.
`default_nettype none
module otpp_dev_model
  import otpp_pkg::*;
(
  input  wire logic [1:0]        vpp_in,
  input  wire logic [1:0]        mode_in,
  input  wire logic [1:0]        cs_in,
  input  wire logic [1:0]        oe_in,
  input  wire logic              strobe_n_in,
  input  wire logic              vcc_raise_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] pins_in,
  input  wire logic [4:0]        need_in,
  output logic                   drive_out,
  output logic [DATA_W-1:0]      dout_out,
  output var logic               mem_lock_out,
  output var logic               ram_lock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [4:0]        hits = 5'h00;
  logic [ADDR_W-1:0] last = '1;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem_lock_out = 1'b0;
    ram_lock_out = 1'b0;
  end
  assign drive_out = cs_in == LVL_LOW && oe_in == LVL_LOW && strobe_n_in &&
                     (mode_in == LVL_HV || (vpp_in == LVL_HV && vcc_raise_in));
  // A locked array answers with a corrupted byte rather than going quiet.
  assign dout_out  = mem_lock_out ? ~mem[addr_in] : mem[addr_in];
  // A byte takes need_in pulses before its cells flip, so slow parts can be mimicked.
  // Pins are judged once the edge has settled, so a zero-time glitch on the strobe is not a pulse.
  always @(negedge strobe_n_in) begin
    #1;
    if (!strobe_n_in) begin
      if (vpp_in == LVL_HV && cs_in == LVL_LOW && oe_in == LVL_HIGH) begin
        hits = (addr_in == last) ? hits + 5'h01 : 5'h01;
        last = addr_in;
        if (hits >= need_in && !mem_lock_out) mem[addr_in] = mem[addr_in] & pins_in;
      end
      if (vpp_in == LVL_HV && mode_in == LVL_HV && cs_in == LVL_HV && oe_in == LVL_HIGH) mem_lock_out = 1'b1;
      if (vpp_in == LVL_HV && mode_in == LVL_HIGH && cs_in == LVL_HV && oe_in == LVL_HV) ram_lock_out = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/otpp_tb_top.sv */
// Self-checking bench for the OTP programmer against a behavioural memory model.
// Assumes shortened pulse parameters; inputs change on the falling clock edge.
`default_nettype none
module otpp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import otpp_pkg::*;
  localparam int unsigned PC = 10;
  localparam int unsigned OC = 20;
  localparam int unsigned MT = 4;
  logic              clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0;
  logic [2:0]        cmd_in = 3'h0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = 8'h00, rdata_out, data_out, dout, pins;
  logic              cmd_ready_out, done_out, fail_out, program_strobe_n_out, vcc_raise_out, data_oe_n_out, drive;
  logic [4:0]        tries_out, need = 5'h01;
  logic [1:0]        vpp_level_out, mode_select_hv_out, chip_sel_out, out_en_out;
  logic [ADDR_W-1:0] addr_out;
  logic              mem_lock, ram_lock;
  int                err_total = 0, checked = 0, low_cyc = 0;
  always #2 clk_in = ~clk_in;
  assign pins = !data_oe_n_out ? data_out : drive ? dout : 8'hff;
  otpp_top #(.PULSE_CYCLES(PC), .OPT_PULSE_CYCLES(OC), .MAX_TRIES(MT)) u_otpp_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out), .fail_out(fail_out),
    .rdata_out(rdata_out), .tries_out(tries_out), .vpp_level_out(vpp_level_out),
    .mode_select_hv_out(mode_select_hv_out), .chip_sel_out(chip_sel_out), .out_en_out(out_en_out),
    .program_strobe_n_out(program_strobe_n_out), .vcc_raise_out(vcc_raise_out), .addr_out(addr_out),
    .data_out(data_out), .data_oe_n_out(data_oe_n_out), .data_in(pins));
  otpp_dev_model u_otpp_dev_model (
    .vpp_in(vpp_level_out), .mode_in(mode_select_hv_out), .cs_in(chip_sel_out), .oe_in(out_en_out),
    .strobe_n_in(program_strobe_n_out), .vcc_raise_in(vcc_raise_out), .addr_in(addr_out), .pins_in(pins),
    .need_in(need), .drive_out(drive), .dout_out(dout), .mem_lock_out(mem_lock), .ram_lock_out(ram_lock));
  task automatic complete_run();
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Issues one command and counts strobe-low cycles until done, with a bounded wait.
  task automatic run(input logic [2:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    cmd_in = c;
    addr_in = a;
    wdata_in = d;
    cmd_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    low_cyc = 0;
    for (n = 0; n < 40000 && done_out !== 1'b1; n++) begin
      @(negedge clk_in);
      if (program_strobe_n_out === 1'b0) low_cyc++;
    end
    if (n == 40000) begin
      err_total++;
      complete_run();
    end
    @(negedge clk_in);
  endtask
  task automatic t_reset_levels();
    chk({cmd_ready_out, program_strobe_n_out, data_oe_n_out, done_out}, 4'he);
    chk({vpp_level_out, mode_select_hv_out, chip_sel_out, out_en_out}, 8'h15);
  endtask
  task automatic t_read_erased();
    run(CMD_READ, 13'h0123, 8'h00);
    chk(rdata_out, 8'hff);
    run(3'h7, 13'h0000, 8'h00);
    chk(fail_out, 1'b0);
    chk(low_cyc, 0);
  endtask
  task automatic t_program();
    logic [4:0] k;
    for (k = 5'h01; k <= MT; k = k + 5'(MT - 1)) begin
      need = k;
      run(CMD_PROGRAM, 13'h0456 + k, 8'h5a ^ k);
      chk(fail_out, 1'b0);
      chk(tries_out, k);
      chk(low_cyc, 4 * k * PC);
      run(CMD_VERIFY, 13'h0456 + k, 8'h00);
      chk(rdata_out, 8'h5a ^ k);
      run(CMD_READ, 13'h0456 + k, 8'h00);
      chk(rdata_out, 8'h5a ^ k);
    end
  endtask
  task automatic t_give_up();
    need = 5'(MT + 1);
    run(CMD_PROGRAM, 13'h1fff, 8'h00);
    chk(fail_out, 1'b1);
    chk(tries_out, MT);
    chk(low_cyc, MT * PC);
  endtask
  task automatic t_ram_protect();
    run(CMD_RAM_PROTECT, 13'h0000, 8'h00);
    chk(low_cyc >= OC, 1'b1);
    chk({ram_lock, mem_lock}, 2'h2);
    run(CMD_READ, 13'h0457, 8'h00);
    chk(rdata_out, 8'h5b);
  endtask
  task automatic t_mem_protect();
    run(CMD_MEM_PROTECT, 13'h0000, 8'h00);
    chk(low_cyc >= OC, 1'b1);
    chk(mem_lock, 1'b1);
    run(CMD_READ, 13'h0457, 8'h00);
    chk(rdata_out, 8'ha4);
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    t_reset_levels();
    rst_n_in = 1'b1;
    @(negedge clk_in);
    t_read_erased();
    t_program();
    t_give_up();
    t_ram_protect();
    t_mem_protect();
    complete_run();
  end
endmodule
`default_nettype wire
